// ---- spe_entry.sv ----
// Operation
// - Data pin two-way, clock pin is input
// - Program/Verify mode passes serial data inward
// - High-voltage entry needs clock, data low
// - Low-voltage entry only when enable bit one
// - Enable bit zero blocks low-voltage entry
// - Capture 32 key bits on clock edges
// - Low-voltage session lasts while master-clear low
// - Enable bit one forces master-clear reset on
// - Enable bit cleared only in high-voltage session
`timescale 1ns/1ps
`default_nettype none
`include "spe_params.svh"
module spe_entry (
    input  wire logic                  clock_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  prog_clock_pin_i,
    input  wire logic                  prog_data_pin_i,
    output logic                       prog_data_pin_o,
    output logic                       prog_data_pin_oe_o,
    input  wire logic                  master_clear_pin_i,
    input  wire logic                  high_entry_voltage_level_i,
    input  wire logic                  low_voltage_entry_enable_i,
    input  wire logic                  mclr_reset_cfg_i,
    input  wire logic                  en_clear_req_i,
    output logic                       en_clear_grant_o,
    output logic                       mclr_reset_enable_o,
    input  wire logic                  read_bit_i,
    input  wire logic                  read_drive_i,
    output spe_pkg::spe_word_type      word_data_o,
    output logic                       word_valid_o,
    input  wire logic                  word_ready_i,
    output spe_pkg::spe_status_type    status_o
);
    import spe_pkg::*;

    // Synchronised pins; the four pin inputs are sampled in clock_i domain
    logic clk_s;
    logic dat_s;
    logic mclr_s;
    logic hv_s;

    spe_sync u_sync_clk (
        .clk_i   (clock_i),
        .rst_b_i (rst_b_i),
        .d_i     (prog_clock_pin_i),
        .q_o     (clk_s)
    );
    spe_sync u_sync_dat (
        .clk_i   (clock_i),
        .rst_b_i (rst_b_i),
        .d_i     (prog_data_pin_i),
        .q_o     (dat_s)
    );
    spe_sync u_sync_mclr (
        .clk_i   (clock_i),
        .rst_b_i (rst_b_i),
        .d_i     (master_clear_pin_i),
        .q_o     (mclr_s)
    );
    spe_sync u_sync_hv (
        .clk_i   (clock_i),
        .rst_b_i (rst_b_i),
        .d_i     (high_entry_voltage_level_i),
        .q_o     (hv_s)
    );

    spe_state_type                state_reg;
    spe_state_type                state_next;
    logic                         clk_d_reg;
    logic                         mclr_d_reg;
    logic [`SPE_KEY_BITS-1:0]     key_reg;
    logic [`SPE_KEY_BITS-1:0]     key_next;
    logic [`SPE_KEY_CNT_W-1:0]    kcnt_reg;
    logic [`SPE_KEY_CNT_W-1:0]    kcnt_next;
    logic [`SPE_WORD_BITS-1:0]    sh_reg;
    logic [`SPE_WORD_BITS-1:0]    sh_next;
    logic [2:0]                   bcnt_reg;
    logic [2:0]                   bcnt_next;
    logic                         push_valid;
    logic                         push_ready;
    logic                         clk_rise;
    logic                         in_prog;
    logic                         dout_reg;
    logic                         doe_reg;

    assign clk_rise = clk_s && !clk_d_reg;
    assign in_prog  = (state_reg == SPE_PROG_LV) || (state_reg == SPE_PROG_HV);

    // Entry state machine and shift registers
    always_comb begin
        state_next = state_reg;
        key_next   = key_reg;
        kcnt_next  = kcnt_reg;
        sh_next    = sh_reg;
        bcnt_next  = bcnt_reg;
        push_valid = 1'b0;
        unique case (state_reg)
            SPE_IDLE: begin
                key_next  = '0;
                kcnt_next = '0;
                if (hv_s && !clk_s && !dat_s) begin
                    state_next = SPE_PROG_HV;
                end else if (!mclr_s && mclr_d_reg && low_voltage_entry_enable_i) begin
                    state_next = SPE_KEY_SHIFT;
                end
            end
            SPE_KEY_SHIFT: begin
                if (mclr_s || !low_voltage_entry_enable_i) begin
                    state_next = SPE_IDLE;
                end else if (kcnt_reg == 6'(`SPE_KEY_BITS)) begin
                    state_next = (key_reg == `SPE_KEY_PATTERN) ? SPE_PROG_LV
                                                              : SPE_LOCKED;
                end else if (clk_rise) begin
                    key_next  = {key_reg[`SPE_KEY_BITS-2:0], dat_s};
                    kcnt_next = kcnt_reg + 1'b1;
                end
            end
            SPE_LOCKED: begin
                if (mclr_s) state_next = SPE_IDLE;
            end
            SPE_PROG_LV, SPE_PROG_HV: begin
                if ((state_reg == SPE_PROG_LV && mclr_s) ||
                    (state_reg == SPE_PROG_HV && !hv_s)) begin
                    state_next = SPE_IDLE;
                    bcnt_next  = '0;
                end else if (clk_rise && !read_drive_i) begin
                    // Serial bits assembled into words, LSB first
                    sh_next = {dat_s, sh_reg[`SPE_WORD_BITS-1:1]};
                    if (bcnt_reg == 3'h7) begin
                        push_valid = 1'b1;
                    end
                    bcnt_next = bcnt_reg + 1'b1;
                end
            end
            default: state_next = SPE_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg  <= SPE_IDLE;
            clk_d_reg  <= 1'b0;
            mclr_d_reg <= 1'b1;
            key_reg    <= '0;
            kcnt_reg   <= '0;
            sh_reg     <= '0;
            bcnt_reg   <= '0;
        end else begin
            state_reg  <= state_next;
            clk_d_reg  <= clk_s;
            mclr_d_reg <= mclr_s;
            key_reg    <= key_next;
            kcnt_reg   <= kcnt_next;
            sh_reg     <= sh_next;
            bcnt_reg   <= bcnt_next;
        end
    end

    // Words for the core; a full buffer drops the word rather than stall the pin
    spe_fifo #(
        .WIDTH (`SPE_WORD_BITS),
        .DEPTH (`SPE_FIFO_DEPTH),
        .PTR_W (`SPE_FIFO_PTR_W)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .flush_i     (!in_prog),
        .in_data_i   ({dat_s, sh_reg[`SPE_WORD_BITS-1:1]}),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .out_data_o  (word_data_o.data),
        .out_valid_o (word_valid_o),
        .out_ready_i (word_ready_i)
    );

    // Data pin turned round for read-back only inside a session
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dout_reg <= 1'b0;
            doe_reg  <= 1'b0;
        end else begin
            dout_reg <= read_bit_i;
            doe_reg  <= in_prog && read_drive_i;
        end
    end
    assign prog_data_pin_o    = dout_reg;
    assign prog_data_pin_oe_o = doe_reg;

    // Master-clear reset cannot be turned off while low-voltage entry enabled
    assign mclr_reset_enable_o = mclr_reset_cfg_i || low_voltage_entry_enable_i;
    // Clearing the enable bit allowed only in a high-voltage session
    assign en_clear_grant_o    = en_clear_req_i && (state_reg == SPE_PROG_HV);

    assign status_o.prog_mode  = in_prog;
    assign status_o.hv_session = (state_reg == SPE_PROG_HV);
    assign status_o.key_failed = (state_reg == SPE_LOCKED);

    // Overflow is not signalled; the core must drain fast enough
    logic unused_ready;
    assign unused_ready = push_ready;
endmodule : spe_entry
`default_nettype wire

// ---- spe_entry_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module spe_entry_monitor (
    input wire logic                   clock_i,
    input wire logic                   rst_b_i,
    input wire logic                   prog_clock_pin_i,
    input wire logic                   prog_data_pin_i,
    input wire logic                   master_clear_pin_i,
    input wire logic                   high_entry_voltage_level_i,
    input wire logic                   low_voltage_entry_enable_i,
    input wire logic                   mclr_reset_cfg_i,
    input wire logic                   en_clear_req_i,
    input wire logic                   en_clear_grant_o,
    input wire logic                   mclr_reset_enable_o,
    input wire spe_pkg::spe_word_type  word_data_o,
    input wire logic                   word_valid_o,
    input wire logic                   word_ready_i,
    input wire spe_pkg::spe_status_type status_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // Steps of the entry and session behaviour
    sequence s_lv_mode; status_o.prog_mode && !status_o.hv_session; endsequence
    sequence s_hv_entry;
        $rose(high_entry_voltage_level_i) && !prog_clock_pin_i && !prog_data_pin_i && !status_o.prog_mode;
    endsequence
    sequence s_lock_hold; (!master_clear_pin_i && status_o.key_failed)[*3]; endsequence
    a_reset_forced_on: assert property (mclr_reset_enable_o == (mclr_reset_cfg_i | low_voltage_entry_enable_i))
        else $error("reset function not forced");
    a_clear_hv_only: assert property (en_clear_grant_o == (en_clear_req_i && status_o.hv_session))
        else $error("enable clear granted outside hv session");
    a_fail_no_mode: assert property (status_o.key_failed |-> !status_o.prog_mode)
        else $error("mode entered after bad key");
    a_lock_holds: assert property (s_lock_hold |=> status_o.key_failed)
        else $error("lockout left while clear low");
    a_lv_exit: assert property (s_lv_mode ##0 $rose(master_clear_pin_i) |-> ##[1:6] !status_o.prog_mode)
        else $error("lv session outlived clear release");
    a_hv_enter: assert property (s_hv_entry |-> ##[1:8] (status_o.prog_mode && status_o.hv_session))
        else $error("hv entry not taken");
    a_lv_needs_en: assert property ($rose(status_o.prog_mode) && !status_o.hv_session
        |-> $past(low_voltage_entry_enable_i))
        else $error("lv entry without enable");
    a_lv_off_blocks: assert property ((!low_voltage_entry_enable_i)[*2]
        |-> !($rose(status_o.prog_mode) && !status_o.hv_session))
        else $error("lv entry while disabled");
    a_word_holds: assert property (word_valid_o && !word_ready_i ##1 status_o.prog_mode
        |-> word_valid_o && $stable(word_data_o))
        else $error("stalled word changed");
endmodule : spe_entry_monitor
`default_nettype wire

// ---- spe_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module spe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int PTR_W = 4
) (
    input  wire logic             clock_i,
    input  wire logic             rst_b_i,
    input  wire logic             flush_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W:0]   wr_ptr_reg;
    logic [PTR_W:0]   wr_ptr_next;
    logic [PTR_W:0]   rd_ptr_reg;
    logic [PTR_W:0]   rd_ptr_next;
    logic             push;
    logic             pop;

    // Honest full and empty from the extra pointer bit
    assign in_ready_o  = (wr_ptr_reg[PTR_W] == rd_ptr_reg[PTR_W]) ||
                         (wr_ptr_reg[PTR_W-1:0] != rd_ptr_reg[PTR_W-1:0]);
    assign out_valid_o = (wr_ptr_reg != rd_ptr_reg);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_reg[rd_ptr_reg[PTR_W-1:0]];

    // Pointer update; flush empties the buffer when a session ends
    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        if (flush_i) begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
        end else begin
            if (push) wr_ptr_next = wr_ptr_reg + 1'b1;
            if (pop)  rd_ptr_next = rd_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    // Storage carries no reset to keep it small
    always_ff @(posedge clock_i) begin
        if (push && !flush_i) begin
            mem_reg[wr_ptr_reg[PTR_W-1:0]] <= in_data_i;
        end
    end
endmodule : spe_fifo
`default_nettype wire

// ---- spe_params.svh ----
`ifndef SPE_PARAMS_SVH
`define SPE_PARAMS_SVH

// Width of the low-voltage entry key
`define SPE_KEY_BITS       32
// Width of the key bit counter
`define SPE_KEY_CNT_W      6
// Entry pattern compared against the shifted key (neutral default)
`define SPE_KEY_PATTERN    32'h5A5A_C3C3
// Serial word width carried to the core side
`define SPE_WORD_BITS      8
// Depth of the word FIFO
`define SPE_FIFO_DEPTH     16
// Pointer width for the FIFO (depth 16)
`define SPE_FIFO_PTR_W     4

`endif

// ---- spe_pkg.sv ----
package spe_pkg;
    // Entry state of the programming port
    typedef enum logic [2:0] {
        SPE_IDLE,
        SPE_KEY_SHIFT,
        SPE_LOCKED,
        SPE_PROG_LV,
        SPE_PROG_HV
    } spe_state_type;

    // Word shifted in from the programmer
    typedef struct packed {
        logic [7:0] data;
    } spe_word_type;

    // Mode status bundle towards the core
    typedef struct packed {
        logic prog_mode;
        logic hv_session;
        logic key_failed;
    } spe_status_type;
endpackage : spe_pkg

// ---- spe_programmer.sv ----
`timescale 1ns/1ps
`default_nettype none
module spe_programmer (
    output logic prog_clock_pin_o,
    output logic prog_data_pin_o,
    output logic master_clear_pin_o,
    output logic high_entry_voltage_level_o
);
    // Clock stands low between frames; clear idles high
    initial begin
        prog_clock_pin_o = 1'b0;
        prog_data_pin_o = 1'b0;
        master_clear_pin_o = 1'b1;
        high_entry_voltage_level_o = 1'b0;
    end
    // One bit per 32 ns link period
    task automatic bit_out(input logic b);
        prog_data_pin_o = b;
        #16 prog_clock_pin_o = 1'b1;
        #16 prog_clock_pin_o = 1'b0;
    endtask : bit_out
    task automatic send_word(input logic [7:0] w);
        for (int i = 0; i < 8; i++) bit_out(w[i]);
        prog_data_pin_o = ~prog_data_pin_o; // Line inverted after the last bit: no stale value
        #32; // Gap so the next word's first bit is a separate change
    endtask : send_word
    task automatic hv_enter();
        prog_data_pin_o = 1'b0;
        #40 high_entry_voltage_level_o = 1'b1;
    endtask : hv_enter
    task automatic hv_leave();
        high_entry_voltage_level_o = 1'b0;
    endtask : hv_leave
    task automatic lv_enter(input logic [31:0] k);
        #40 master_clear_pin_o = 1'b0;
        #40 for (int i = 31; i >= 0; i--) bit_out(k[i]);
        prog_data_pin_o = ~prog_data_pin_o;
    endtask : lv_enter
    task automatic lv_leave();
        master_clear_pin_o = 1'b1;
    endtask : lv_leave
endmodule : spe_programmer
`default_nettype wire

// ---- spe_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module spe_sync (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_reg;
    logic sync_reg;

    // Two-stage synchroniser; first stage read only by second
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;
endmodule : spe_sync
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spe_params.svh"
module tb;
    import spe_pkg::*;
    logic           clock_i, rst_b_i, pclk, pdat, mclr, hv, en, cfg, req, grant, rst_en;
    logic           rd_bit, rd_drv, dout, doe, wvalid, wready, dlevel;
    spe_word_type   wdata;
    spe_status_type status_o;
    int             failures, comparisons, cycles;
    // Wire level: device wins while it drives
    assign dlevel = doe ? dout : pdat;
    spe_programmer u_prog (.prog_clock_pin_o(pclk), .prog_data_pin_o(pdat), .master_clear_pin_o(mclr),
        .high_entry_voltage_level_o(hv));
    spe_entry u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .prog_clock_pin_i(pclk), .prog_data_pin_i(dlevel),
        .prog_data_pin_o(dout), .prog_data_pin_oe_o(doe), .master_clear_pin_i(mclr),
        .high_entry_voltage_level_i(hv), .low_voltage_entry_enable_i(en), .mclr_reset_cfg_i(cfg),
        .en_clear_req_i(req), .en_clear_grant_o(grant), .mclr_reset_enable_o(rst_en), .read_bit_i(rd_bit),
        .read_drive_i(rd_drv), .word_data_o(wdata), .word_valid_o(wvalid), .word_ready_i(wready),
        .status_o(status_o));
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    // Hang guard, far above the expected run
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask : cyc
    task automatic wait_mode(input logic exp);
        for (int i = 0; i < 40 && status_o.prog_mode !== exp; i++) cyc(1);
    endtask : wait_mode
    // Low-voltage attempt with a given key and enable bit
    task automatic scen_lv(input logic [31:0] k, input logic e, input logic mode, input logic fail);
        cyc(1);
        en = e;
        u_prog.lv_enter(k);
        cyc(8);
        check(status_o.prog_mode, mode);
        check(status_o.key_failed, fail);
        req = 1'b1;
        cyc(1);
        check(grant, 1'b0);
        req = 1'b0;
        u_prog.lv_leave();
        cyc(8);
        check(status_o.prog_mode, 1'b0);
        check(status_o.key_failed, 1'b0);
    endtask : scen_lv
    // HV session: clear grant, read-back drive, FIFO fill past full
    task automatic scen_hv();
        u_prog.hv_enter();
        wait_mode(1'b1);
        check(status_o.hv_session, 1'b1);
        req = 1'b1;
        cyc(1);
        check(grant, 1'b1);
        {req, rd_drv, rd_bit} = 3'h3;
        cyc(4);
        check({doe, dout}, 8'h03);
        rd_drv = 1'b0;
        cyc(4);
        for (int i = 0; i < 17; i++) u_prog.send_word(8'hA0 + i[7:0]);
        cyc(4);
        for (int i = 0; i < 16; i++) begin
            check(wvalid, 1'b1);
            check(wdata, 8'hA0 + i[7:0]);
            wready = 1'b1;
            cyc(1);
            wready = 1'b0;
            cyc(1);
        end
        check(wvalid, 1'b0);
        u_prog.hv_leave();
        wait_mode(1'b0);
        check(status_o.prog_mode, 1'b0);
    endtask : scen_hv
    initial begin
        {rst_b_i, en, cfg, req, rd_bit, rd_drv, wready} = 7'h00;
        cyc(3);
        rst_b_i = 1'b1;
        cyc(3);
        en = 1'b1;
        cyc(1);
        check(rst_en, 1'b1);
        scen_lv(`SPE_KEY_PATTERN, 1'b1, 1'b1, 1'b0);
        scen_lv(~`SPE_KEY_PATTERN, 1'b1, 1'b0, 1'b1);
        scen_lv(`SPE_KEY_PATTERN, 1'b0, 1'b0, 1'b0);
        check(rst_en, 1'b0);
        cfg = 1'b1;
        cyc(1);
        check(rst_en, 1'b1);
        cfg = 1'b0;
        cyc(1);
        scen_hv();
        report_and_stop();
    end
endmodule : tb
bind spe_entry spe_entry_monitor u_mon (.clock_i(clock_i), .rst_b_i(rst_b_i), .prog_clock_pin_i(prog_clock_pin_i),
    .prog_data_pin_i(prog_data_pin_i), .master_clear_pin_i(master_clear_pin_i),
    .high_entry_voltage_level_i(high_entry_voltage_level_i), .low_voltage_entry_enable_i(low_voltage_entry_enable_i),
    .mclr_reset_cfg_i(mclr_reset_cfg_i), .en_clear_req_i(en_clear_req_i), .en_clear_grant_o(en_clear_grant_o),
    .mclr_reset_enable_o(mclr_reset_enable_o), .word_data_o(word_data_o), .word_valid_o(word_valid_o),
    .word_ready_i(word_ready_i), .status_o(status_o));
`default_nettype wire
